// ===== azo_pkg.sv
// package of constants, types and register map for the alarm zone output option block
// Functional notes
// - trouble text: 0 check style, 1 trouble style
// - fire lock holds display, star advances
// - open/short supervisory option selects open response
// - waterflow silenced by off or restore
// - per-bell pulsing or steady output
// - zone 17/18 delay count times two seconds
// - alarm only if faulted whole delay
// - extended option multiplies delay by four
// - type 18 uses delay only if enabled
// - zone 6 alternate function is tamper
// - aux alternate: serial tx on trigger pin 5, rx from radio pin
// - trigger modes 0 and 1 output mapping
// - trigger mode 2 indicator lamp mapping
// - dialing attempts limited to 1..8
// - dialer used only when enable set
// - backup dialer pulse 0, tone 1
// - restore report per zone type enable; only types 17 and 18 are wired, OPT_REST16 has no effect
// - bell 1 reset on second off option
// - bell 2 reset on second off option
// - arming ding bell2/aux lasts two half-second ticks
package azo_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HALF_SEC_MS = 500;
    localparam int unsigned HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
    localparam logic [3:0] DELAY_STEP_S = 4'h2;
    localparam logic [2:0] EXT_FACTOR = 3'h4;
    localparam logic [3:0] PULSE_HALF_TICKS = 4'h1;

    // register byte offsets
    localparam logic [7:0] OFF_OPT = 8'h00;
    localparam logic [7:0] OFF_DELAY = 8'h04;
    localparam logic [7:0] OFF_DIAL = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_TRIG = 8'h14;

    // option register bit positions
    localparam int OPT_TROUBLE_TEXT = 0;
    localparam int OPT_FLOCK = 1;
    localparam int OPT_Z18USE = 2;
    localparam int OPT_SUPOS = 3;
    localparam int OPT_WFSIL = 4;
    localparam int OPT_STEADY1 = 5;
    localparam int OPT_STEADY2 = 6;
    localparam int OPT_Z6ALT = 7;
    localparam int OPT_EXT = 8;
    localparam int OPT_AUXALT = 9;
    localparam int OPT_MODE_LO = 10;
    localparam int OPT_RST2OFF1 = 12;
    localparam int OPT_RST2OFF2 = 13;
    localparam int OPT_DING2 = 14;
    localparam int OPT_DINGAUX = 15;
    localparam int OPT_REST16 = 16;
    localparam int OPT_REST17 = 17;
    localparam int OPT_REST18 = 18;
    localparam logic [31:0] OPT_RESET = 32'h0000_0000;

    // dial register bit positions
    localparam int DIAL_MAIN_EN = 0;
    localparam int DIAL_BACK_EN = 1;
    localparam int DIAL_TONE = 2;
    localparam int DIAL_MAX_LO = 4;
    localparam logic [3:0] DIAL_MAX_DEF = 4'h3;

    // command register bits (write one to pulse)
    localparam int CMD_OFF = 0;
    localparam int CMD_STAR = 1;
    localparam int CMD_EXIT_END = 2;
    localparam int CMD_KISSOFF = 3;
    localparam int CMD_CLOSE_RPT = 4;
    localparam int CMD_DIAL_FAIL = 5;
    localparam int CMD_DIAL_OK = 6;
    localparam int CMD_TROUBLE_CLR = 7;

    typedef enum logic [1:0] {
        AZO_LOOP_NORMAL = 2'b00,
        AZO_LOOP_OPEN = 2'b01,
        AZO_LOOP_SHORT = 2'b10
    } azo_loop_t;

    typedef enum logic [1:0] {
        AZO_TRIG_SOUNDER = 2'b00,
        AZO_TRIG_KEYSW = 2'b01,
        AZO_TRIG_LAMPS = 2'b10
    } azo_trig_mode_t;

    typedef enum logic [1:0] {
        AZO_Q_IDLE = 2'b00,
        AZO_Q_TIMING = 2'b01,
        AZO_Q_ALARM = 2'b10
    } azo_q_state_t;

    typedef struct packed {
        logic panic;
        logic burglary;
        logic ac_fail;
        logic ready;
        logic armed;
        logic open_close;
        logic serial_tx;
    } azo_sys_in_t;

    typedef struct packed {
        logic [1:0] z17_loop;
        logic [1:0] z18_loop;
        logic [1:0] sup_loop;
        logic z6_fault;
    } azo_loops_t;
endpackage

// ===== azo_core.sv
// alarm zone output option logic with an axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module azo_core
    import azo_pkg::*;
#(
    parameter int unsigned HALF_SEC = HALF_SEC_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] sys_in,
    input wire logic [6:0] loop_pins,
    input wire logic radio_send_ok_input,
    output logic serial_rx,
    output logic radio_ok,
    output logic [6:0] trigger_connector,
    output logic bell1,
    output logic bell2,
    output logic aux_relay,
    output logic trouble_text,
    output logic tamper,
    output logic dial_main_go,
    output logic dial_backup_go,
    output logic dial_tone
);
    // loop and radio inputs come from pins: two flip-flops each
    logic [7:0] sync1, sync2;
    azo_loops_t loops;
    azo_sys_in_t sys;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end
        else
        begin
            sync1 <= {radio_send_ok_input, loop_pins};
            sync2 <= sync1;
        end
    end
    assign loops = sync2[6:0];
    assign sys = sys_in;

    // registers
    logic [31:0] opt;
    logic [7:0] dly;
    logic [7:0] dial;
    logic [7:0] cmd_pulse;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic do_write;
    assign do_write = aw_hold && w_hold && !s_axi_bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = be[i] ? nv[i*8 +: 8] : old[i*8 +: 8];
    endfunction

    logic [3:0] w_strb;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                s_axi_wready <= 1'b0;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == OFF_OPT || aw_addr == OFF_DELAY ||
                                aw_addr == OFF_DIAL || aw_addr == OFF_CMD) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opt <= OPT_RESET;
            dly <= 8'h00;
            dial <= {DIAL_MAX_DEF, 4'h0};
            cmd_pulse <= 8'h00;
        end
        else
        begin
            cmd_pulse <= 8'h00;
            if (do_write)
            begin
                case (aw_addr)
                    OFF_OPT: opt <= merge(opt, w_data, w_strb);
                    OFF_DELAY: if (w_strb[0]) dly <= {3'h0, w_data[4:0]};
                    OFF_DIAL:
                    begin
                        if (w_strb[0])
                        begin
                            // out-of-range attempt limits are clamped into 1..8
                            dial[3:0] <= {1'b0, w_data[2:0]};
                            if (w_data[7:4] == 4'h0)
                                dial[7:4] <= 4'h1;
                            else if (w_data[7:4] > 4'h8)
                                dial[7:4] <= 4'h8;
                            else
                                dial[7:4] <= w_data[7:4];
                        end
                    end
                    OFF_CMD: if (w_strb[0]) cmd_pulse <= w_data[7:0];
                    default: ;
                endcase
            end
        end
    end

    // one-second and half-second ticks from one divider
    logic [31:0] div;
    logic half_tick, sec_tick, half_phase;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div <= 32'h0;
            half_tick <= 1'b0;
            half_phase <= 1'b0;
        end
        else
        begin
            half_tick <= 1'b0;
            if (div == HALF_SEC - 1)
            begin
                div <= 32'h0;
                half_tick <= 1'b1;
                half_phase <= !half_phase;
            end
            else
                div <= div + 32'h1;
        end
    end
    assign sec_tick = half_tick && half_phase;

    // qualification delay for types 17 and 18
    logic [3:0] dcount;
    logic [7:0] delay_s;
    assign dcount = dly[3:0];
    assign delay_s = opt[OPT_EXT] ? 8'(dcount * DELAY_STEP_S * EXT_FACTOR)
                                  : 8'(dcount * DELAY_STEP_S);

    function automatic logic faulted(input logic [1:0] l);
        faulted = (l != AZO_LOOP_NORMAL);
    endfunction

    azo_q_state_t q_state [2];
    logic [7:0] q_cnt [2];
    logic [1:0] q_alarm, q_prev, restore_evt;
    logic [1:0] q_fault;
    logic [7:0] q_need [2];
    assign q_fault = {faulted(loops.z18_loop), faulted(loops.z17_loop)};
    assign q_need[0] = delay_s;
    assign q_need[1] = opt[OPT_Z18USE] ? delay_s : 8'h00;

    for (genvar z = 0; z < 2; z++)
    begin : g_q
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                q_state[z] <= AZO_Q_IDLE;
                q_cnt[z] <= 8'h00;
            end
            else
            begin
                case (q_state[z])
                    AZO_Q_IDLE:
                        if (q_fault[z])
                        begin
                            q_cnt[z] <= 8'h00;
                            q_state[z] <= (q_need[z] == 8'h00) ? AZO_Q_ALARM : AZO_Q_TIMING;
                        end
                    AZO_Q_TIMING:
                        if (!q_fault[z])
                        begin
                            q_state[z] <= AZO_Q_IDLE;
                            q_cnt[z] <= 8'h00;
                        end
                        else if (sec_tick)
                        begin
                            if (q_cnt[z] + 8'h1 >= q_need[z])
                                q_state[z] <= AZO_Q_ALARM;
                            q_cnt[z] <= q_cnt[z] + 8'h1;
                        end
                    AZO_Q_ALARM:
                        if (!q_fault[z])
                            q_state[z] <= AZO_Q_IDLE;
                    default: q_state[z] <= AZO_Q_IDLE;
                endcase
            end
        end
        assign q_alarm[z] = (q_state[z] == AZO_Q_ALARM);
    end

    // supervisory from the supervised loop or a zone 18 alarm, trouble from the supervised loop
    logic sup_resp, trouble_resp;
    assign sup_resp = (loops.sup_loop == AZO_LOOP_SHORT) ||
                      (opt[OPT_SUPOS] && loops.sup_loop == AZO_LOOP_OPEN) ||
                      q_alarm[1];
    assign trouble_resp = !opt[OPT_SUPOS] && loops.sup_loop == AZO_LOOP_OPEN;

    // fire alarm (waterflow type 17) latch with silence handling
    logic fire_latch, wf_sounding, off_count;
    logic [1:0] restore_rpt;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fire_latch <= 1'b0;
            wf_sounding <= 1'b0;
            q_prev <= 2'b00;
            restore_rpt <= 2'b00;
        end
        else
        begin
            q_prev <= q_alarm;
            if (cmd_pulse[CMD_OFF] && !wf_sounding)
                fire_latch <= 1'b0;
            if (q_alarm[0] && !q_prev[0])
            begin
                fire_latch <= 1'b1;
                wf_sounding <= 1'b1;
            end
            else if (opt[OPT_WFSIL] ? (!q_alarm[0] && q_prev[0]) : cmd_pulse[CMD_OFF])
                wf_sounding <= 1'b0;
            restore_rpt <= restore_evt & {opt[OPT_REST18], opt[OPT_REST17]};
        end
    end
    assign restore_evt = q_prev & ~q_alarm;

    // bell reset after fire: first or second off entry
    logic b1_on, b2_on, off_seen;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            b1_on <= 1'b0;
            b2_on <= 1'b0;
            off_seen <= 1'b0;
        end
        else if (q_alarm[0] && !q_prev[0])
        begin
            b1_on <= 1'b1;
            b2_on <= 1'b1;
            off_seen <= 1'b0;
        end
        else if (cmd_pulse[CMD_OFF])
        begin
            off_seen <= 1'b1;
            if (!opt[OPT_RST2OFF1] || off_seen)
                b1_on <= 1'b0;
            if (!opt[OPT_RST2OFF2] || off_seen)
                b2_on <= 1'b0;
        end
    end
    assign off_count = off_seen;

    // arming ding: end of exit delay, or kissoff when closing reports are sent
    logic ding_go;
    logic [3:0] ding_cnt;
    assign ding_go = cmd_pulse[CMD_CLOSE_RPT] ? cmd_pulse[CMD_KISSOFF]
                                             : cmd_pulse[CMD_EXIT_END];
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ding_cnt <= 4'h0;
        else if (ding_go)
            ding_cnt <= PULSE_HALF_TICKS + 4'h1;
        else if (half_tick && ding_cnt != 4'h0)
            ding_cnt <= ding_cnt - 4'h1;
    end

    // fire display lock: cursor held on first alarm, star steps
    logic disp_adv;
    assign disp_adv = opt[OPT_FLOCK] ? cmd_pulse[CMD_STAR] : sec_tick;

    // dialer attempt counter
    logic [3:0] attempts;
    logic dial_active;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            attempts <= 4'h0;
            dial_active <= 1'b0;
        end
        else if (restore_rpt != 2'b00 || (q_alarm[0] && !q_prev[0]))
        begin
            attempts <= 4'h0;
            dial_active <= 1'b1;
        end
        else if (cmd_pulse[CMD_DIAL_OK])
            dial_active <= 1'b0;
        else if (cmd_pulse[CMD_DIAL_FAIL] && dial_active)
        begin
            attempts <= attempts + 4'h1;
            if (attempts + 4'h1 >= dial[7:4])
                dial_active <= 1'b0;
        end
    end

    // output mapping
    logic pulse_phase;
    logic [6:0] next_trig;
    logic [7:0] disp_pos;
    azo_trig_mode_t mode;
    assign mode = azo_trig_mode_t'(opt[OPT_MODE_LO +: 2]);
    assign pulse_phase = half_phase;
    always_comb
    begin
        case (mode)
            AZO_TRIG_KEYSW: next_trig = {sys.armed, sys.ready, fire_latch, sup_resp,
                                         sys.burglary, trouble_resp, sys.panic};
            AZO_TRIG_LAMPS: next_trig = {sys.ac_fail, dial_active && dial[DIAL_BACK_EN],
                                         fire_latch, sup_resp, attempts != 4'h0,
                                         trouble_resp, dial_active && dial[DIAL_MAIN_EN]};
            default: next_trig = {sys.open_close, b2_on, fire_latch, sup_resp,
                                  sys.burglary, trouble_resp, sys.panic};
        endcase
        if (opt[OPT_AUXALT])
            next_trig[4] = sys.serial_tx;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trigger_connector <= 7'h00;
            bell1 <= 1'b0;
            bell2 <= 1'b0;
            aux_relay <= 1'b0;
            trouble_text <= 1'b0;
            tamper <= 1'b0;
            serial_rx <= 1'b0;
            radio_ok <= 1'b0;
            dial_main_go <= 1'b0;
            dial_backup_go <= 1'b0;
            dial_tone <= 1'b0;
            disp_pos <= 8'h00;
        end
        else
        begin
            trigger_connector <= next_trig;
            bell1 <= b1_on && wf_sounding && (opt[OPT_STEADY1] || pulse_phase);
            bell2 <= (b2_on && wf_sounding && (opt[OPT_STEADY2] || pulse_phase)) ||
                     (opt[OPT_DING2] && ding_cnt != 4'h0);
            aux_relay <= opt[OPT_DINGAUX] && ding_cnt != 4'h0;
            trouble_text <= opt[OPT_TROUBLE_TEXT];
            tamper <= opt[OPT_Z6ALT] && loops.z6_fault;
            serial_rx <= opt[OPT_AUXALT] && sync2[7];
            radio_ok <= !opt[OPT_AUXALT] && sync2[7];
            dial_main_go <= dial_active && dial[DIAL_MAIN_EN];
            dial_backup_go <= dial_active && dial[DIAL_BACK_EN];
            dial_tone <= dial[DIAL_TONE];
            if (!fire_latch)
                disp_pos <= 8'h00;
            else if (disp_adv)
                disp_pos <= disp_pos + 8'h1;
        end
    end

    // read channel: one cycle after address is taken
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_arready <= 1'b1;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            s_axi_arready <= 1'b0;
            case (s_axi_araddr)
                OFF_OPT: s_axi_rdata <= opt;
                OFF_DELAY: s_axi_rdata <= {24'h0, dly};
                OFF_DIAL: s_axi_rdata <= {24'h0, dial};
                OFF_CMD: s_axi_rdata <= 32'h0;
                OFF_STAT: s_axi_rdata <= {8'h0, disp_pos, attempts, restore_rpt, off_count,
                                          dial_active, trouble_resp, sup_resp, fire_latch,
                                          wf_sounding, q_alarm, q_fault};
                OFF_TRIG: s_axi_rdata <= {25'h0, trigger_connector};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // azo_core

// ===== azo_asserts.sv
// port-level checks for the alarm zone option block
`timescale 1ns/1ps
module azo_asserts
    import azo_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [6:0] sys_in,
    input wire logic [6:0] loop_pins,
    input wire logic serial_rx,
    input wire logic radio_ok,
    input wire logic [6:0] trigger_connector,
    input wire logic bell1,
    input wire logic tamper,
    input wire logic trouble_text
);
    logic [7:0] wa;
    logic [31:0] wd;
    logic [31:0] op;
    logic busy;
    logic busy_d;
    logic quiet;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            wa <= 8'h00;
        else if (s_axi_awvalid && s_axi_awready)
            wa <= s_axi_awaddr;
    // shadow lags the design, so checks wait until a write has fully settled
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
        begin
            wd <= 32'h0000_0000;
            busy <= 1'b0;
            busy_d <= 1'b0;
        end
        else
        begin
            busy_d <= busy;
            if (s_axi_wvalid && s_axi_wready)
                wd <= s_axi_wdata;
            if (s_axi_wvalid && s_axi_wready)
                busy <= 1'b1;
            else if (s_axi_bvalid && s_axi_bready)
                busy <= 1'b0;
        end
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            op <= OPT_RESET;
        else if (s_axi_bvalid && s_axi_bready && wa == OFF_OPT && s_axi_bresp == 2'b00)
            op <= wd;
    assign quiet = !busy && !busy_d;
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rst; $rose(rst_n) |-> !(bell1 || tamper) && trigger_connector == 7'h00; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_txt; quiet |-> trouble_text == op[OPT_TROUBLE_TEXT]; endproperty
    a_txt: assert property (p_txt) else $error("trouble text differs from option");
    property p_tmp; tamper |-> $past(loop_pins[0], 3) || $past(loop_pins[0], 4); endproperty
    a_tmp: assert property (p_tmp) else $error("tamper without zone 6 fault");
    property p_tmo; quiet && tamper |-> op[OPT_Z6ALT]; endproperty
    a_tmo: assert property (p_tmo) else $error("tamper with zone 6 option off");
    property p_rad; !(serial_rx && radio_ok); endproperty
    a_rad: assert property (p_rad) else $error("radio pin routed to both roles");
    property p_pan; quiet && op[11:10] == 2'b00 |-> trigger_connector[0] == $past(sys_in[6]); endproperty
    a_pan: assert property (p_pan) else $error("pin 1 not panic in mode 0");
    property p_lmp; quiet && op[11:10] == 2'b10 |-> trigger_connector[6] == $past(sys_in[4]); endproperty
    a_lmp: assert property (p_lmp) else $error("pin 7 not ac lamp in mode 2");
    property p_wr; s_both_taken |-> ##[1:3] s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_ar; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
    a_ar: assert property (p_ar) else $error("read response late");
endmodule // azo_asserts

// ===== azo_field.sv
// field wiring model: zone loops and radio pin
`timescale 1ns/1ps
module azo_field
    import azo_pkg::*;
(
    input wire logic clock,
    input wire azo_loops_t want,
    input wire logic radio_want,
    output azo_loops_t loop_pins,
    output logic radio_send_ok_input
);
    // contacts move just after an edge, never on it
    always @(posedge clock)
    begin
        loop_pins <= want;
        radio_send_ok_input <= radio_want;
    end
    initial
    begin
        loop_pins = '0;
        radio_send_ok_input = 1'b0;
    end
endmodule // azo_field

// ===== azo_core_bench.sv
// self-checking bench for the alarm zone option block
`timescale 1ns/1ps
module azo_core_bench
    import azo_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, radio_want = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    azo_sys_in_t sys_in = '0;
    azo_loops_t want = '0;
    azo_loops_t loop_pins;
    logic radio_send_ok_input, serial_rx, radio_ok, bell1, bell2, aux_relay;
    logic trouble_text, tamper, dial_main_go, dial_backup_go, dial_tone;
    logic [6:0] trigger_connector;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    // half second of ten cycles keeps the qualification delays short
    azo_core #(.HALF_SEC(10)) dut (.*);
    azo_field fld (.*);
    always #12.5 clock = ~clock;
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw)
        begin
            @(posedge clock);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        while (s_axi_bvalid !== 1'b1)
            @(posedge clock);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge clock);
        while (s_axi_arready !== 1'b1)
            @(posedge clock);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
            @(posedge clock);
        chk("rdata", e, s_axi_rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic t_opts;
        logic [31:0] ov [2] = '{32'h81, 32'h200};
        logic [3:0] ev [2] = '{4'b1101, 4'b0010};
        want.z6_fault <= 1'b1;
        radio_want <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            axw(OFF_OPT, ov[i], 2'b00);
            tick(6);
            chk("opt_out", {28'h0, ev[i]}, {28'h0, trouble_text, tamper, serial_rx, radio_ok});
        end
        want.z6_fault <= 1'b0;
        radio_want <= 1'b0;
    endtask
    task automatic t_trig;
        logic [6:0] ex [3] = '{7'h45, 7'h25, 7'h00};
        sys_in <= 7'b1101010;
        for (int i = 0; i < 3; i++)
        begin
            axw(OFF_OPT, 32'(i) << 10, 2'b00);
            tick(3);
            chk("trigger", {25'h0, ex[i]}, {25'h0, trigger_connector});
        end
        sys_in <= '0;
    endtask
    task automatic t_delay;
        axw(OFF_DELAY, 32'h2, 2'b00);
        axw(OFF_OPT, 32'h20, 2'b00);
        want.z17_loop <= AZO_LOOP_SHORT;
        tick(50);
        want.z17_loop <= AZO_LOOP_NORMAL;
        tick(5);
        want.z17_loop <= AZO_LOOP_SHORT;
        tick(50);
        axr(OFF_STAT, 32'h4, 32'h0, 2'b00);
        tick(40);
        axr(OFF_STAT, 32'h4, 32'h4, 2'b00);
        chk("bell1", 32'h1, {31'h0, bell1});
        chk("dial", 32'h7, {29'h0, dial_main_go, dial_backup_go, dial_tone});
        axw(OFF_CMD, 32'h1, 2'b00);
        tick(3);
        chk("bells", 32'h0, {29'h0, bell1, bell2, aux_relay});
        axw(OFF_OPT, 32'h104, 2'b00);
        want.z18_loop <= AZO_LOOP_SHORT;
        tick(200);
        axr(OFF_STAT, 32'h8, 32'h0, 2'b00);
        tick(150);
        axr(OFF_STAT, 32'h8, 32'h8, 2'b00);
    endtask
    task automatic t_dial;
        logic [3:0] wv [3] = '{4'h0, 4'h9, 4'h5};
        logic [3:0] ev [3] = '{4'h1, 4'h8, 4'h5};
        for (int i = 0; i < 3; i++)
        begin
            axw(OFF_DIAL, {24'h0, wv[i], 4'h7}, 2'b00);
            axr(OFF_DIAL, 32'hf7, {24'h0, ev[i], 4'h7}, 2'b00);
        end
    endtask
    initial
    begin
        tick(12);
        rst_n <= 1'b1;
        chk("idle", 32'h0, {24'h0, bell1, trigger_connector});
        axr(OFF_DIAL, 32'hff, 32'h30, 2'b00);
        axr(8'h20, 32'hffff_ffff, 32'h0, 2'b10);
        axw(OFF_STAT, 32'h1, 2'b10);
        t_opts();
        t_trig();
        t_dial();
        t_delay();
        close_out();
    end
endmodule // azo_core_bench
bind azo_core azo_asserts u_chk (.*);
